// ---- tpoc_defines.svh ----
// Offsets, field positions and reset values of the option control block.
// Included by its bare name; it defines constants only.
`ifndef TPOC_DEFINES_SVH
`define TPOC_DEFINES_SVH

// ==========================================================
// Register map (Wishbone byte addresses)
`define TPOC_OFS_OPTION 4'h0
`define TPOC_OFS_STATUS 4'h4
`define TPOC_OFS_PULLUP 4'h8

// ==========================================================
// Option register fields
`define TPOC_BIT_PULLUP_DIS 7
`define TPOC_BIT_IRQ_EDGE 6
`define TPOC_BIT_CLK_SRC 5
`define TPOC_BIT_SRC_EDGE 4
`define TPOC_BIT_PS_ASSIGN 3
`define TPOC_RATE_MSB 2
`define TPOC_RATE_LSB 0
`define TPOC_OPTION_RESET 8'hff
`define TPOC_PULLUP_RESET 8'h00

`endif

// ---- tpoc_pkg.sv ----
// Types shared by the option control block.
// Assumes tpoc_defines.svh holds the numeric constants.
package tpoc_pkg;
    // Which unit the shared prescaler serves
    typedef enum logic [0:0] {
        TPOC_PS_TIMER = 1'b0,
        TPOC_PS_WDOG = 1'b1
    } tpoc_assign_type;
endpackage : tpoc_pkg

// ---- tpoc_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin and one system clock.
`timescale 1ns/1ps
module tpoc_pin_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pinIn,
    output logic levelOut,
    output logic riseOut,
    output logic fallOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic agree;

    // ==========================================================
    // Synchroniser chain; the stable level changes when stages 2 and 3 agree
    assign agree = (s2_q == s3_q);
    assign riseOut = agree && s3_q && !lvl_q;
    assign fallOut = agree && !s3_q && lvl_q;
    assign levelOut = lvl_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                lvl_q <= s3_q;
            end
        end
    end
endmodule : tpoc_pin_sync

// ---- tpoc_prescaler.sv ----
// Shared 8-bit ripple-free prescaler with a power-of-two tap select.
// Assumes the caller gives one event pulse per input tick.
`timescale 1ns/1ps
module tpoc_prescaler (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tickIn,
    input wire logic [3:0] log2Div,
    output logic tickOut
);
    logic [7:0] cnt_q;
    logic [8:0] mask;

    // ==========================================================
    // Output fires when the low log2Div bits wrap to zero
    assign mask = (9'h001 << log2Div) - 9'h001;
    assign tickOut = tickIn && ((cnt_q & mask[7:0]) == mask[7:0]);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else if (tickIn) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : tpoc_prescaler

// ---- tpoc_option_ctrl.sv ----
// Option control register with timer source, edge, prescaler and pull-up steering.
// Assumes a classic Wishbone master on clk_sys and asynchronous pins.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "tpoc_defines.svh"
module tpoc_option_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic extIrqPin,
    input wire logic timerExtClockPin,
    input wire logic watchdogTickIn,
    output logic [7:0] pullupEnable,
    output logic extIrqRequest,
    output logic timerZeroTick,
    output logic watchdogTick,
    output logic [7:0] timerZeroCounter
);
    // ==========================================================
    // Registers
    logic [7:0] option_q;
    logic [7:0] pinPullup_q;
    logic [31:0] dat_q;
    logic ack_q;
    logic [7:0] pullup_q;
    logic irq_q;
    logic tmrTick_q;
    logic wdTick_q;
    logic [7:0] count_q;

    // ==========================================================
    // Helper functions
    // Edge choice shared by the interrupt pin and the timer clock pin
    function automatic logic pickEdge(input logic wantRise, input logic riseEv,
        input logic fallEv);
        pickEdge = wantRise ? riseEv : fallEv;
    endfunction : pickEdge

    // Division exponent; the timer side always divides by at least two
    function automatic logic [3:0] rateLog2(input logic forWdog, input logic [2:0] field);
        rateLog2 = forWdog ? {1'b0, field} : ({1'b0, field} + 4'h1);
    endfunction : rateLog2

    // ==========================================================
    // Option register layout
    // Bit 7 global pull-up off, bit 6 interrupt edge, bit 5 timer source
    // Bit 4 pin edge, bit 3 prescaler owner, bits 2:0 division rate
    // Every bit is plain read/write; no bit has a side effect on access
    // Changing the owner does not clear the shared count, so the first
    // divided tick after a switch may come early; software must allow it
    // ==========================================================
    // Decode of option fields
    wire pullupDis = option_q[`TPOC_BIT_PULLUP_DIS];
    wire irqEdge = option_q[`TPOC_BIT_IRQ_EDGE];
    wire clkSrc = option_q[`TPOC_BIT_CLK_SRC];
    wire srcEdge = option_q[`TPOC_BIT_SRC_EDGE];
    wire [2:0] rate = option_q[`TPOC_RATE_MSB:`TPOC_RATE_LSB];
    tpoc_pkg::tpoc_assign_type psOwner;
    assign psOwner = tpoc_pkg::tpoc_assign_type'(option_q[`TPOC_BIT_PS_ASSIGN]);

    // ==========================================================
    // Pin synchronisers
    wire irqRise;
    wire irqFall;
    wire tckRise;
    wire tckFall;

    tpoc_pin_sync u_irqSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pinIn(extIrqPin),
        .levelOut(),
        .riseOut(irqRise),
        .fallOut(irqFall)
    );

    tpoc_pin_sync u_tckSync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pinIn(timerExtClockPin),
        .levelOut(),
        .riseOut(tckRise),
        .fallOut(tckFall)
    );

    // Interrupt edge choice
    wire irqEvent = pickEdge(irqEdge, irqRise, irqFall);

    // Timer source: pin edge or every instruction cycle
    wire pinEvent = pickEdge(!srcEdge, tckRise, tckFall);
    wire timerSrc = clkSrc ? pinEvent : 1'b1;

    // ==========================================================
    // Shared prescaler; only one consumer is routed to it at a time
    wire toWdog = (psOwner == tpoc_pkg::TPOC_PS_WDOG);
    wire psIn = toWdog ? watchdogTickIn : timerSrc;
    wire [3:0] psLog2 = rateLog2(toWdog, rate);
    wire psOut;

    tpoc_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tickIn(psIn),
        .log2Div(psLog2),
        .tickOut(psOut)
    );

    // Timer bypasses the prescaler when the watchdog owns it, giving 1:1
    wire tmrEvent = toWdog ? timerSrc : psOut;
    wire wdEvent = toWdog ? psOut : watchdogTickIn;

    // Pull-up gating; global bit is active-low enable
    wire [7:0] pullupNext = pullupDis ? 8'h00 : pinPullup_q;

    // ==========================================================
    // Wishbone decode
    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    // Write lands on the edge where the master samples ack high
    wire wrLow = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    wire hitOpt = (wb_adr_i == `TPOC_OFS_OPTION);
    wire hitSts = (wb_adr_i == `TPOC_OFS_STATUS);
    wire hitPup = (wb_adr_i == `TPOC_OFS_PULLUP);
    wire [31:0] rdMux = hitOpt ? {24'h000000, option_q} :
                        hitSts ? {24'h000000, count_q} :
                        hitPup ? {24'h000000, pinPullup_q} : 32'h00000000;

    // Register writes; unmapped addresses are acked and ignored
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            option_q <= `TPOC_OPTION_RESET;
            pinPullup_q <= `TPOC_PULLUP_RESET;
        end else begin
            if (wrLow && hitOpt) begin
                option_q <= wb_dat_i[7:0];
            end
            if (wrLow && hitPup) begin
                pinPullup_q <= wb_dat_i[7:0];
            end
        end
    end

    // Single-cycle answer, ack dropped the next cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            dat_q <= req ? rdMux : 32'h00000000;
        end
    end

    // ==========================================================
    // Registered outputs and the minimal timer counter
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pullup_q <= 8'h00;
            irq_q <= 1'b0;
            tmrTick_q <= 1'b0;
            wdTick_q <= 1'b0;
            count_q <= 8'h00;
        end else begin
            pullup_q <= pullupNext;
            irq_q <= irqEvent;
            tmrTick_q <= tmrEvent;
            wdTick_q <= wdEvent;
            if (tmrEvent) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign pullupEnable = pullup_q;
    assign extIrqRequest = irq_q;
    assign timerZeroTick = tmrTick_q;
    assign watchdogTick = wdTick_q;
    assign timerZeroCounter = count_q;
endmodule : tpoc_option_ctrl

// ---- tpoc_checker.sv ----
// Checker: bus answers, interrupt pulses and pull-up reset of the option block.
// Assumes it is bound to tpoc_option_ctrl and sees only its ports.
`timescale 1ns/1ps
module tpoc_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic extIrqPin,
    input wire logic [7:0] pullupEnable,
    input wire logic extIrqRequest
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Open request, and a pin that has not moved for eight cycles
    sequence reqS;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence quietS;
        $stable(extIrqPin) [*8];
    endsequence
    a_ack_follows: assert property (reqS |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits");
    // Filter delay is short, so eight still cycles leave no request
    a_irq_quiet: assert property (quietS |-> !extIrqRequest) else $error("irq");
    a_irq_pulse: assert property (extIrqRequest |=> !extIrqRequest) else $error("irq");
    a_pullup_reset: assert property ($fell(sys_rst) |-> pullupEnable == 8'h0)
        else $error("pull-up");
endmodule : tpoc_checker
bind tpoc_option_ctrl tpoc_checker chk_u (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .extIrqPin, .pullupEnable, .extIrqRequest);

// ---- tpoc_pin_model.sv ----
// Pin-side model: drives the interrupt pin and the timer clock pin.
// Assumes the bench calls setPins from its own sequence.
`timescale 1ns/1ps
module tpoc_pin_model (
    input wire logic clk_sys,
    output logic irqPin = 1'b0,
    output logic clkPin = 1'b0
);
    // ==========================================================
    // Move both pins after an edge, then hold for holdCyc cycles
    task automatic setPins(input logic lvl, input int holdCyc);
        @(posedge clk_sys);
        irqPin <= lvl;
        clkPin <= lvl;
        repeat (holdCyc) @(posedge clk_sys);
    endtask : setPins
endmodule : tpoc_pin_model

// ---- tpoc_option_ctrl_bench.sv ----
// Bench: option access, pull-up gating, pin edges and prescaler rates.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module tpoc_option_ctrl_bench;
    logic clk_sys = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic watchdogTickIn = 1'b0, win = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat, expTmr;
    logic wb_ack_o, extIrqPin, timerExtClockPin, extIrqRequest, timerZeroTick, watchdogTick;
    logic [7:0] pullupEnable, timerZeroCounter, cnt0, tmrDelta;
    logic [15:0] nIrq, nTmr, nWd;
    int err_total = 0, num_checks = 0, cycles = 0;
    initial forever #50 clk_sys = ~clk_sys;
    tpoc_pin_model pin_u (.clk_sys, .irqPin(extIrqPin), .clkPin(timerExtClockPin));
    tpoc_option_ctrl dut_u (.*);
    // ==========================================================
    // Window counters clear while closed; watchdog base tick every other cycle
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        watchdogTickIn <= ~watchdogTickIn;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
        if (win) begin
            {nIrq, nTmr, nWd} <= {nIrq + 16'(extIrqRequest), nTmr + 16'(timerZeroTick),
                nWd + 16'(watchdogTick)};
        end else begin
            {nIrq, nTmr, nWd} <= 48'h0;
        end
    end
    // Classic cycle; read data is taken at the edge where ack is seen
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
        input logic [7:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, 24'h0, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask : check
    // Settle after the write so select changes land outside the window
    task automatic measure(input logic [7:0] opt, input logic lvl, input int hold);
        wb(1'b1, 4'h0, 4'h1, opt);
        repeat (8) @(posedge clk_sys);
        cnt0 = timerZeroCounter;
        win <= 1'b1;
        pin_u.setPins(lvl, hold);
        tmrDelta = timerZeroCounter - cnt0;
        win <= 1'b0;
        // One more edge so the last window sample has landed
        @(posedge clk_sys);
    endtask : measure
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b1, 4'h8, 4'h1, 8'h3c);
        wb(1'b1, 4'h0, 4'h0, 8'h5a);
        wb(1'b0, 4'h0, 4'h1, 8'h00);
        check("option", 32'hff, rdat);
        check("pullups", 32'h0, 32'(pullupEnable));
        wb(1'b1, 4'h0, 4'h1, 8'h5a);
        wb(1'b0, 4'h0, 4'h1, 8'h00);
        check("option", 32'h5a, rdat);
        check("pullups", 32'h3c, 32'(pullupEnable));
        wb(1'b0, 4'h8, 4'h1, 8'h00);
        check("pin pullups", 32'h3c, rdat);
        wb(1'b0, 4'hc, 4'h1, 8'h00);
        check("unmapped", 32'h0, rdat);
        // Whole periods in a 512-cycle window make the count phase-free
        for (int r = 0; r < 16; r++) begin
            measure({4'h8, r[3:0]}, 1'b0, 511);
            expTmr = r[3] ? 32'h200 : 32'h100 >> r[2:0];
            check("timer", expTmr, 32'(nTmr));
            check("counter", {24'h0, expTmr[7:0]}, 32'(tmrDelta));
            check("watchdog", r[3] ? 32'h100 >> r[2:0] : 32'h100, 32'(nWd));
        end
        check("pullups", 32'h0, 32'(pullupEnable));
        for (int k = 0; k < 4; k++) begin
            measure({1'b1, k[1], 1'b1, k[1], 4'h8}, ~k[0], 11);
            check("timer edge", {31'h0, ~k[0] ^ k[1]}, 32'(nTmr));
            check("counter edge", {31'h0, ~k[0] ^ k[1]}, 32'(tmrDelta));
            check("irq edge", {31'h0, k[0] ^ k[1]}, 32'(nIrq));
            wb(1'b0, 4'h4, 4'h1, 8'h00);
            check("status", {24'h0, cnt0 + {7'h00, ~k[0] ^ k[1]}}, rdat);
        end
        // Second reset mid-run restores the option and pin pull-up values
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b0, 4'h0, 4'h1, 8'h00);
        check("option after reset", 32'hff, rdat);
        wb(1'b0, 4'h8, 4'h1, 8'h00);
        check("pin pullups after reset", 32'h0, rdat);
        test_done();
    end
endmodule : tpoc_option_ctrl_bench
